// file: verilog/pdc_pkg.sv
// Package for the divider and phase configuration register bank.
// Assumes byte-wide register access from the serial port engine on one clock.
package pdc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned NUM_REGS = 12;
    localparam int unsigned ADDR_W = 15;
    localparam logic [14:0] ADDR_INT_LOW = 15'h0010;
    localparam logic [14:0] ADDR_INT_HIGH = 15'h0011;
    localparam logic [14:0] ADDR_CAL_PRESCALE = 15'h0012;
    localparam logic [14:0] ADDR_PRI_FRAC0 = 15'h0014;
    localparam logic [14:0] ADDR_PRI_PRIMARY_FRACTION = 15'h0015;
    localparam logic [14:0] ADDR_PRI_AUXILIARY_FRACTION = 15'h0016;
    localparam logic [14:0] ADDR_FRAC_SHARED = 15'h0017;
    localparam logic [14:0] ADDR_AUX_FRAC_HIGH = 15'h0018;
    localparam logic [14:0] ADDR_AUX_MOD_LOW = 15'h0019;
    localparam logic [14:0] ADDR_AUX_MOD_HIGH = 15'h001a;
    localparam logic [14:0] ADDR_PHASE0 = 15'h001b;
    localparam logic [14:0] ADDR_PHASE1 = 15'h001c;
    localparam logic [14:0] ADDR_PHASE2 = 15'h001d;

    // ****************************************
    // Storage index of each register except 0x10, which is not stored
    // ****************************************
    localparam int unsigned IDX_INT_HIGH = 0;
    localparam int unsigned IDX_CAL_PRESCALE = 1;
    localparam int unsigned IDX_PRI_FRAC0 = 2;
    localparam int unsigned IDX_PRI_PRIMARY_FRACTION = 3;
    localparam int unsigned IDX_PRI_AUXILIARY_FRACTION = 4;
    localparam int unsigned IDX_FRAC_SHARED = 5;
    localparam int unsigned IDX_AUX_FRAC_HIGH = 6;
    localparam int unsigned IDX_AUX_MOD_LOW = 7;
    localparam int unsigned IDX_AUX_MOD_HIGH = 8;
    localparam int unsigned IDX_PHASE0 = 9;
    localparam int unsigned IDX_PHASE1 = 10;
    localparam int unsigned IDX_PHASE2 = 11;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RESET_INT_LOW = 8'h32;
    localparam logic [7:0] RESET_INT_HIGH = 8'h00;
    localparam logic [7:0] RESET_CAL_PRESCALE = 8'h40;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_AUX_MOD_LOW = 8'he8;
    localparam logic [7:0] RESET_AUX_MOD_HIGH = 8'h03;

    // ****************************************
    // Writable bits and field positions
    // ****************************************
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_CAL_PRESCALE = 8'h60;
    localparam logic [7:0] MASK_LOW7 = 8'h7f;
    localparam int unsigned BIT_AUTOCAL = 6;
    localparam int unsigned BIT_PRESCALE = 5;
    localparam int unsigned BIT_PHASE_EN = 6;
    localparam int unsigned BIT_PRI_FRAC_TOP = 0;
    localparam int unsigned INT_W = 16;
    localparam int unsigned PRI_FRAC_W = 25;
    localparam int unsigned AUX_W = 14;
    localparam int unsigned PHASE_W = 24;

    localparam logic [NUM_REGS-1:0][14:0] REG_ADDRS = {
        ADDR_PHASE2, ADDR_PHASE1, ADDR_PHASE0, ADDR_AUX_MOD_HIGH,
        ADDR_AUX_MOD_LOW, ADDR_AUX_FRAC_HIGH, ADDR_FRAC_SHARED, ADDR_PRI_AUXILIARY_FRACTION,
        ADDR_PRI_PRIMARY_FRACTION, ADDR_PRI_FRAC0, ADDR_CAL_PRESCALE, ADDR_INT_HIGH};
    localparam logic [NUM_REGS-1:0][7:0] REG_RESETS = {
        RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_AUX_MOD_HIGH,
        RESET_AUX_MOD_LOW, RESET_ZERO, RESET_ZERO, RESET_ZERO,
        RESET_ZERO, RESET_ZERO, RESET_CAL_PRESCALE, RESET_INT_HIGH};
    localparam logic [NUM_REGS-1:0][7:0] REG_MASKS = {
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_LOW7,
        MASK_FULL, MASK_LOW7, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_CAL_PRESCALE, MASK_FULL};

endpackage

// file: verilog/pdc_phase_accum.sv
// Output phase offset accumulator for the phase adjust function.
// Assumes step requests are one-cycle pulses on the core clock.
`timescale 1ns/1ps
module pdc_phase_accum
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_soft_reset,
    input wire logic i_enable,
    input wire logic i_step,
    input wire logic [23:0] i_phase_value,
    output logic [23:0] o_phase_offset,
    output logic o_phase_step
);

    typedef struct packed
    {
        logic [23:0] offset;
        logic step;
    } pdc_accum_s;

    pdc_accum_s cur;
    pdc_accum_s next_cur;

    // ****************************************
    // Incremental advance, wraps at one full cycle
    // ****************************************
    always_comb
    begin
        next_cur = cur;
        next_cur.step = 1'b0;
        if (i_soft_reset)
        begin
            next_cur = '0;
        end
        else if (i_step && i_enable)
        begin
            next_cur.offset = cur.offset + i_phase_value;
            next_cur.step = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign o_phase_offset = cur.offset;
    assign o_phase_step = cur.step;

endmodule

// file: verilog/pdc_config_regs.sv
// Divider and phase configuration register bank with double-buffered divider values.
// Assumes the serial port engine delivers single-cycle byte accesses on i_core_clk.
//
// Summary of operation
// - The upper integer divide byte lives at 0x11, read/write, resetting to zero.
// - Bit 6 at 0x12 enables oscillator band autocalibration; that register resets to 0x40.
// - Bit 5 at 0x12 selects the prescaler: zero gives 4/5, one gives 8/9.
// - The 25-bit primary fraction is built from 0x14, 0x15, 0x16 and bit 0 of 0x17.
// - The 14-bit auxiliary fraction is 0x17 bits 7:1 low and 0x18 bits 6:0 high.
// - The 14-bit auxiliary modulus is 0x19 low and 0x1A bits 5:0 high, reset 0x3E8.
// - Bit 6 at 0x1A enables phase adjustment and resets to zero.
// - An enabled phase adjust advances the output phase relative to its present phase.
// - The 24-bit phase value spans 0x1B, 0x1C and 0x1D, low byte first, reset zero.
// - The applied shift is the phase value over 16,777,216 of a full 360 degrees.
// - Integer, fractions and modulus take effect only when the byte at 0x10 is written.
`timescale 1ns/1ps
module pdc_config_regs
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_soft_reset,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [14:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic [15:0] o_int_word,
    output logic [24:0] o_primary_fraction_value,
    output logic [13:0] o_auxiliary_fraction_value,
    output logic [13:0] o_auxiliary_modulus_value,
    output logic o_prescaler_8_9,
    output logic o_auto_band_calibration_enable,
    output logic o_phase_shift_enable,
    output logic [23:0] o_phase_value,
    output logic [23:0] o_phase_offset,
    output logic o_phase_step,
    output logic o_divider_update,
    output logic o_autocal_start,
    output logic o_update_pending
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        logic [pdc_pkg::NUM_REGS-1:0][7:0] regs;
        logic [15:0] act_int;
        logic [24:0] act_pri;
        logic [13:0] act_aux_frac;
        logic [13:0] act_aux_mod;
        logic pending;
        logic [7:0] rd_data;
        logic rd_valid;
        logic update;
        logic autocal_start;
    } pdc_state_s;

    localparam pdc_state_s STATE_RESET = '{
        regs: pdc_pkg::REG_RESETS,
        act_int: {pdc_pkg::RESET_INT_HIGH, pdc_pkg::RESET_INT_LOW},
        act_pri: 25'h000_0000,
        act_aux_frac: 14'h0000,
        act_aux_mod: {pdc_pkg::RESET_AUX_MOD_HIGH[5:0], pdc_pkg::RESET_AUX_MOD_LOW},
        pending: 1'b0,
        rd_data: 8'h00,
        rd_valid: 1'b0,
        update: 1'b0,
        autocal_start: 1'b0};

    pdc_state_s cur;
    pdc_state_s next_cur;

    logic [pdc_pkg::NUM_REGS-1:0] hit;
    logic int_low_write;
    logic [15:0] shadow_int;
    logic [24:0] shadow_pri;
    logic [13:0] shadow_aux_frac;
    logic [13:0] shadow_aux_mod;
    logic [23:0] phase_value;

    // ****************************************
    // Address decode
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < pdc_pkg::NUM_REGS; g++)
        begin : gen_hit
            assign hit[g] = (i_addr == pdc_pkg::REG_ADDRS[g]);
        end
    endgenerate

    assign int_low_write = i_wr_en && (i_addr == pdc_pkg::ADDR_INT_LOW);

    // ****************************************
    // Shadow words assembled from the byte registers; the integer low byte comes from the write data
    // ****************************************
    assign shadow_int = {cur.regs[pdc_pkg::IDX_INT_HIGH], i_wr_data};
    assign shadow_pri = {
        cur.regs[pdc_pkg::IDX_FRAC_SHARED][pdc_pkg::BIT_PRI_FRAC_TOP],
        cur.regs[pdc_pkg::IDX_PRI_AUXILIARY_FRACTION],
        cur.regs[pdc_pkg::IDX_PRI_PRIMARY_FRACTION],
        cur.regs[pdc_pkg::IDX_PRI_FRAC0]};
    assign shadow_aux_frac = {
        cur.regs[pdc_pkg::IDX_AUX_FRAC_HIGH][6:0],
        cur.regs[pdc_pkg::IDX_FRAC_SHARED][7:1]};
    assign shadow_aux_mod = {
        cur.regs[pdc_pkg::IDX_AUX_MOD_HIGH][5:0],
        cur.regs[pdc_pkg::IDX_AUX_MOD_LOW]};
    assign phase_value = {
        cur.regs[pdc_pkg::IDX_PHASE2],
        cur.regs[pdc_pkg::IDX_PHASE1],
        cur.regs[pdc_pkg::IDX_PHASE0]};

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic [7:0] rd_word;
        rd_word = 8'h00;
        next_cur = cur;
        next_cur.rd_valid = 1'b0;
        next_cur.update = 1'b0;
        next_cur.autocal_start = 1'b0;
        for (int i = 0; i < pdc_pkg::NUM_REGS; i++)
        begin
            if (hit[i])
            begin
                rd_word = rd_word | cur.regs[i];
            end
        end
        if (i_soft_reset)
        begin
            next_cur = STATE_RESET;
        end
        else
        begin
            // Reserved bits are masked off so they read back as zero
            for (int i = 0; i < pdc_pkg::NUM_REGS; i++)
            begin
                if (i_wr_en && hit[i])
                begin
                    next_cur.regs[i] = i_wr_data & pdc_pkg::REG_MASKS[i];
                end
            end
            if (i_wr_en && (|hit) && !hit[pdc_pkg::IDX_CAL_PRESCALE])
            begin
                next_cur.pending = 1'b1;
            end
            // Transfer the shadow set into the divider as one unit
            if (int_low_write)
            begin
                next_cur.act_int = shadow_int;
                next_cur.act_pri = shadow_pri;
                next_cur.act_aux_frac = shadow_aux_frac;
                next_cur.act_aux_mod = shadow_aux_mod;
                next_cur.pending = 1'b0;
                next_cur.update = 1'b1;
                next_cur.autocal_start =
                    cur.regs[pdc_pkg::IDX_CAL_PRESCALE][pdc_pkg::BIT_AUTOCAL];
            end
            if (i_rd_en && (|hit))
            begin
                next_cur.rd_data = rd_word;
                next_cur.rd_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cur <= STATE_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ****************************************
    // Phase adjust
    // ****************************************
    pdc_phase_accum u_phase_accum
    (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_soft_reset(i_soft_reset),
        .i_enable(o_phase_shift_enable),
        .i_step(cur.update),
        .i_phase_value(phase_value),
        .o_phase_offset(o_phase_offset),
        .o_phase_step(o_phase_step)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign o_rd_data = cur.rd_data;
    assign o_rd_valid = cur.rd_valid;
    assign o_int_word = cur.act_int;
    assign o_primary_fraction_value = cur.act_pri;
    assign o_auxiliary_fraction_value = cur.act_aux_frac;
    assign o_auxiliary_modulus_value = cur.act_aux_mod;
    assign o_prescaler_8_9 =
        cur.regs[pdc_pkg::IDX_CAL_PRESCALE][pdc_pkg::BIT_PRESCALE];
    assign o_auto_band_calibration_enable =
        cur.regs[pdc_pkg::IDX_CAL_PRESCALE][pdc_pkg::BIT_AUTOCAL];
    assign o_phase_shift_enable =
        cur.regs[pdc_pkg::IDX_AUX_MOD_HIGH][pdc_pkg::BIT_PHASE_EN];
    assign o_phase_value = phase_value;
    assign o_divider_update = cur.update;
    assign o_autocal_start = cur.autocal_start;
    assign o_update_pending = cur.pending;

endmodule

// file: testbench/pdc_host_model.sv
// Host model driving the byte register port.
// Assumes the bank samples on the rising clock edge.
`timescale 1ns/1ps
module pdc_host_model
(
    input wire logic i_core_clk,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [14:0] o_addr,
    output logic [7:0] o_wr_data
);
    initial
    begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 15'h0000;
        o_wr_data = 8'h00;
    end
    // Caller keeps integer values legal for the chosen prescaler
    task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_wr_en <= wr;
        o_rd_en <= !wr;
        o_addr <= a;
        o_wr_data <= d;
        @(posedge i_core_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        // Released lines must not keep the last value
        o_addr <= ~a;
        o_wr_data <= ~d;
    endtask
endmodule

// file: testbench/pdc_config_regs_props.sv
// Port checker for the divider and phase register bank.
// Assumes binding onto every pdc_config_regs instance.
`timescale 1ns/1ps
module pdc_config_regs_props
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_soft_reset,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [14:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic o_rd_valid,
    input wire logic [15:0] o_int_word,
    input wire logic [24:0] o_primary_fraction_value,
    input wire logic [13:0] o_auxiliary_fraction_value,
    input wire logic [13:0] o_auxiliary_modulus_value,
    input wire logic o_prescaler_8_9,
    input wire logic o_auto_band_calibration_enable,
    input wire logic o_phase_shift_enable,
    input wire logic [23:0] o_phase_value,
    input wire logic [23:0] o_phase_offset,
    input wire logic o_phase_step,
    input wire logic o_divider_update,
    input wire logic o_autocal_start,
    input wire logic o_update_pending
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic hit, shadow, go, adv;
    logic [1:0] cal_bits;
    assign hit = i_addr inside {15'h0011, 15'h0012, [15'h0014:15'h001d]};
    assign shadow = i_addr inside {15'h0011, [15'h0014:15'h001a]};
    assign go = i_wr_en && i_addr == 15'h0010 && !i_soft_reset;
    assign adv = o_divider_update && o_phase_shift_enable;
    assign cal_bits = i_wr_data[6:5];
    property p_read_answer;
        i_rd_en && hit && !i_soft_reset |=> o_rd_valid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered");
    property p_read_refused;
        !(i_rd_en && hit) |=> !o_rd_valid;
    endproperty
    a_read_refused: assert property (p_read_refused)
        else $error("stray read answer");
    property p_transfer;
        go |=> o_divider_update && !o_update_pending && o_int_word[7:0] == $past(i_wr_data);
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("transfer missing");
    property p_shadow_hold;
        !go && !i_soft_reset |=> $stable({o_int_word, o_primary_fraction_value,
            o_auxiliary_fraction_value, o_auxiliary_modulus_value});
    endproperty
    a_shadow_hold: assert property (p_shadow_hold)
        else $error("divider moved without transfer");
    property p_pending;
        i_wr_en && shadow && !i_soft_reset |=> o_update_pending;
    endproperty
    a_pending: assert property (p_pending)
        else $error("pending not set");
    property p_ctrl;
        i_wr_en && i_addr == 15'h0012 && !i_soft_reset
            |=> {o_auto_band_calibration_enable, o_prescaler_8_9} == $past(cal_bits);
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("control bits wrong");
    property p_autocal;
        o_divider_update |-> o_autocal_start == o_auto_band_calibration_enable;
    endproperty
    a_autocal: assert property (p_autocal)
        else $error("autocal start wrong");
    property p_step;
        adv && !i_soft_reset
            |=> o_phase_step && o_phase_offset == $past(o_phase_offset) + $past(o_phase_value);
    endproperty
    a_step: assert property (p_step)
        else $error("phase step wrong");
    property p_no_step;
        !adv && !i_soft_reset |=> !o_phase_step && $stable(o_phase_offset);
    endproperty
    a_no_step: assert property (p_no_step)
        else $error("stray phase step");
    property p_soft;
        i_soft_reset |=> o_int_word == 16'h0032 && o_auxiliary_modulus_value == 14'h03e8
            && o_auto_band_calibration_enable && !o_phase_shift_enable;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset values wrong");
    c_transfer: cover property (go);
    c_step: cover property (o_phase_step);
    c_refused: cover property (i_rd_en && !hit);
endmodule
bind pdc_config_regs pdc_config_regs_props u_props (.*);

// file: testbench/test_pdc_config_regs.sv
// Self-checking bench for the divider and phase register bank.
// Assumes host model and checker are compiled first.
`timescale 1ns/1ps
module test_pdc_config_regs;
    logic i_core_clk, i_reset_n, i_soft_reset, wr_en, rd_en, rd_valid;
    logic presc, autocal, phase_en, phase_step, div_upd, cal_start, pending;
    logic [14:0] addr;
    logic [7:0] wr_data, rd_data;
    logic [15:0] int_word;
    logic [24:0] pri_frac;
    logic [13:0] aux_frac, aux_mod;
    logic [23:0] phase_val, phase_off;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    pdc_host_model host (.i_core_clk(i_core_clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wr_data(wr_data));
    pdc_config_regs dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_soft_reset(i_soft_reset), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_int_word(int_word), .o_primary_fraction_value(pri_frac),
        .o_auxiliary_fraction_value(aux_frac), .o_auxiliary_modulus_value(aux_mod),
        .o_prescaler_8_9(presc), .o_auto_band_calibration_enable(autocal),
        .o_phase_shift_enable(phase_en), .o_phase_value(phase_val),
        .o_phase_offset(phase_off), .o_phase_step(phase_step), .o_divider_update(div_upd),
        .o_autocal_start(cal_start), .o_update_pending(pending));
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00);
        #1;
        chk("rd_valid", 32'(1'b1), 32'(rd_valid));
        chk("rd_data", 32'(e), 32'(rd_data));
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        for (int i = 0; i < 12; i++)
            rd(pdc_pkg::REG_ADDRS[i], pdc_pkg::REG_RESETS[i]);
        chk("int_word", 32'(16'h0032), 32'(int_word));
        $display("reset test done");
    endtask
    task automatic t_rw();
        for (int i = 0; i < 12; i++)
        begin
            host.access(1'b1, pdc_pkg::REG_ADDRS[i], 8'hff);
            rd(pdc_pkg::REG_ADDRS[i], pdc_pkg::REG_MASKS[i]);
        end
        host.access(1'b1, 15'h0013, 8'hff);
        host.access(1'b0, 15'h0013, 8'h00);
        #1;
        chk("refused", 32'(1'b0), 32'(rd_valid));
        $display("access test done");
    endtask
    task automatic t_xfer();
        logic [14:0] a [8] = '{15'h0011, 15'h0014, 15'h0015, 15'h0016, 15'h0017,
            15'h0018, 15'h0019, 15'h001a};
        logic [7:0] d [8] = '{8'h12, 8'h01, 8'h02, 8'h03, 8'h05, 8'h04, 8'h21, 8'h02};
        for (int i = 0; i < 8; i++)
            host.access(1'b1, a[i], d[i]);
        #1;
        chk("held", 32'(16'h0032), 32'(int_word));
        chk("pending", 32'(1'b1), 32'(pending));
        host.access(1'b1, 15'h0010, 8'h40);
        #1;
        chk("update", 32'(1'b1), 32'(div_upd));
        chk("cleared", 32'(1'b0), 32'(pending));
        chk("cal_start", 32'(1'b1), 32'(cal_start));
        chk("int_word", 32'(16'h1240), 32'(int_word));
        chk("pri_frac", 32'(25'h103_0201), 32'(pri_frac));
        chk("aux_frac", 32'(14'h0202), 32'(aux_frac));
        chk("aux_mod", 32'(14'h0221), 32'(aux_mod));
        $display("transfer test done");
    endtask
    task automatic t_phase();
        host.access(1'b1, 15'h001b, 8'h01);
        host.access(1'b1, 15'h001c, 8'h00);
        host.access(1'b1, 15'h001d, 8'h80);
        host.access(1'b1, 15'h001a, 8'h42);
        host.access(1'b1, 15'h0010, 8'h40);
        host.access(1'b1, 15'h0010, 8'h40);
        @(posedge i_core_clk);
        #1;
        chk("phase_val", 32'(24'h80_0001), 32'(phase_val));
        chk("phase_off", 32'(24'h00_0002), 32'(phase_off));
        chk("phase_step", 32'(1'b1), 32'(phase_step));
        $display("phase test done");
    endtask
    task automatic t_ctrl();
        for (int k = 0; k < 4; k++)
        begin
            host.access(1'b1, 15'h0012, 8'(k << 5));
            #1;
            chk("prescaler", 32'(k % 2), 32'(presc));
            chk("autocal", 32'(k / 2), 32'(autocal));
            host.access(1'b1, 15'h0010, 8'h32);
            #1;
            chk("cal_start", 32'(k / 2), 32'(cal_start));
        end
        @(posedge i_core_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_core_clk);
        i_soft_reset <= 1'b0;
        #1;
        chk("soft_presc", 32'(1'b0), 32'(presc));
        chk("soft_phase_en", 32'(1'b0), 32'(phase_en));
        $display("control test done");
    endtask
    initial
    begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    initial
    begin
        i_reset_n = 1'b0;
        i_soft_reset = 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_rw();
        t_xfer();
        t_phase();
        t_ctrl();
        stop_test();
    end
    always @(posedge i_core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            stop_test();
        end
    end
endmodule
